// [pcmv_codec_model.sv]
// Behavioural codec that follows the voiceband PCM bus master
`timescale 1ns/1ps
`default_nettype none
module pcmv_codec_model (
   input wire logic pcm_clk_i,
   input wire logic frame_sync_pulse_i,
   input wire logic pcm_dout_i,
   input wire pcmv_pkg::pcmv_word_type word_i,
   output logic pcm_din_o,
   output logic frame_o,
   output pcmv_pkg::pcmv_word_type cap_word_o,
   output logic cap_o
);
   import pcmv_pkg::*;
   int idx = 99;
   pcmv_word_type cur = '0;
   logic [WORD_BITS-1:0] shreg = '0;
   initial begin
      pcm_din_o = 1'b0;
      frame_o = 1'b0;
      cap_o = 1'b0;
      cap_word_o = '0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Receive on the falling edge; the sync seen here arms the next word
   always @(negedge pcm_clk_i) begin
      if (frame_sync_pulse_i === 1'b1) begin
         idx <= 0;
         cur <= word_i;
         frame_o <= ~frame_o;
      end else if (idx < WORD_BITS) begin
         shreg <= {shreg[WORD_BITS-2:0], pcm_dout_i};
         idx <= idx + 1;
         if (idx == WORD_BITS - 1) begin
            cap_word_o <= {shreg[WORD_BITS-2:0], pcm_dout_i};
            cap_o <= ~cap_o;
         end
      end
   end
   // Launch MSB first on the rising edge; outside the word the line keeps driving and toggles every bit clock
   always @(posedge pcm_clk_i) begin
      if (idx < WORD_BITS) begin
         pcm_din_o <= cur[WORD_BITS-1-idx];
      end else begin
         pcm_din_o <= ~pcm_din_o;
      end
   end
endmodule
`default_nettype wire

// [pcmv_pkg.sv]
// Constants and carrier types for the voiceband PCM master port
package pcmv_pkg;
   // Clock rates
   localparam int SYS_CLK_HZ = 125_000_000;
   localparam int AUDIO_CLK_HZ = 8_192_000;
   localparam int BIT_CLK_KHZ = 2048;
   localparam int BIT_CLK_HZ = BIT_CLK_KHZ * 1000;
   // Frame timing, in bit clock slots
   localparam int FRAME_PERIOD_US = 125;
   localparam int SLOTS_PER_FRAME = FRAME_PERIOD_US * BIT_CLK_KHZ / 1000;
   localparam int SLOT_W = 8;
   localparam int WORD_BITS = 16;
   localparam int SAMPLE_BITS = 13;
   localparam int PAD_BITS = 3;
   localparam int WORD_IDX_W = 4;
   localparam int FS_SLOT = 0;
   localparam int FIRST_DATA_SLOT = 1;
   localparam int LAST_DATA_SLOT = FIRST_DATA_SLOT + WORD_BITS - 1;
   localparam int LAST_SAMPLE_SLOT = FIRST_DATA_SLOT + SAMPLE_BITS - 1;
   localparam logic [SLOT_W-1:0] SLOT_FS = SLOT_W'(FS_SLOT);
   localparam logic [SLOT_W-1:0] SLOT_FIRST_DATA = SLOT_W'(FIRST_DATA_SLOT);
   localparam logic [SLOT_W-1:0] SLOT_LAST_DATA = SLOT_W'(LAST_DATA_SLOT);
   localparam logic [SLOT_W-1:0] SLOT_LAST_SAMPLE = SLOT_W'(LAST_SAMPLE_SLOT);
   localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOTS_PER_FRAME - 1);
   localparam logic [SLOT_W-1:0] SLOT_STEP = 8'h01;
   // Crossing and buffering
   localparam int SYNC_STAGES = 3;
   localparam int BUF_DEPTH = 2;
   localparam logic [PAD_BITS-1:0] PAD_ZERO = 3'h0;

   // Linear two's complement sample
   typedef logic signed [SAMPLE_BITS-1:0] pcmv_sample_type;

   // Serial word: sample leads, pad bits trail
   typedef struct packed {
      pcmv_sample_type sample;
      logic [PAD_BITS-1:0] pad;
   } pcmv_word_type;
endpackage

// [pcmv_port.sv]
// Voiceband PCM bus master port with clock crossing and sample buffers
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Synchroniser: three stages, level accepted when stages two and three agree
module pcmv_sync (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic d_i,
   output logic q_o,
   output logic chg_o
);
   import pcmv_pkg::*;
   logic [SYNC_STAGES-1:0] stage;
   logic q_prev;

   // Raw shift chain, each stage feeds the next
   always_ff @(posedge clk_i) begin
      stage <= {stage[SYNC_STAGES-2:0], d_i};
   end

   // Agreement filter; one cycle of disagreement never reaches the user
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         q_o <= 1'b0;
         q_prev <= 1'b0;
      end else begin
         if (stage[1] == stage[2]) begin
            q_o <= stage[1];
         end
         q_prev <= q_o;
      end
   end

   assign chg_o = q_o ^ q_prev; // Toggle seen
endmodule

////////////////////////////////////////////////////////////////////////////////
// Shift buffer whose outputs all come straight from flip-flops
module pcmv_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 2
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   logic [WIDTH-1:0] entry [DEPTH];
   logic [WIDTH-1:0] next_entry [DEPTH];
   logic [DEPTH-1:0] full;
   logic [DEPTH-1:0] next_full;
   logic space;
   logic push;
   logic pop;
   logic placed;

   assign push = in_valid_i && space;
   assign pop = full[0] && out_ready_i;

   // Shift on pop, then place a pushed word in the lowest free entry
   always_comb begin
      next_entry = entry;
      next_full = full;
      placed = 1'b0;
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            next_entry[i] = entry[i + 1];
            next_full[i] = full[i + 1];
         end
         next_full[DEPTH-1] = 1'b0;
      end
      if (push) begin
         for (int i = 0; i < DEPTH; i++) begin
            if (!next_full[i] && !placed) begin
               next_entry[i] = in_data_i;
               next_full[i] = 1'b1;
               placed = 1'b1;
            end
         end
      end
   end

   // Storage and flags
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         full <= '0;
         space <= 1'b1;
         for (int i = 0; i < DEPTH; i++) begin
            entry[i] <= '0;
         end
      end else begin
         full <= next_full;
         space <= !next_full[DEPTH-1];
         entry <= next_entry;
      end
   end

   assign in_ready_o = space;
   assign out_valid_o = full[0];
   assign out_data_o = entry[0];
endmodule

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RULE_01: This port is bus master and drives both bit clock and frame sync.
// RULE_02: Four lines: bit clock out, frame sync out, data out, data in.
// RULE_03: Samples travel as linear two's complement in both directions.
// RULE_04: Four formats exist; voiceband drives the bit clock at 2048 kHz.
// RULE_05: Frame sync pulses at 8 kHz, each exactly one bit clock long.
// RULE_06: Each word is 16 bits: 13 sample bits then 3 zero bits.
// RULE_07: After sync falls, both sides move 16 bits over 16 consecutive clocks.
// RULE_08: After the 16 bits, data lines stay inactive until the next sync; the codec model toggles din every bit clock until then.
// RULE_09: Each side should float its data output outside the word; the codec model never floats din and toggles it there.
// RULE_10: Application floats its PCM lines while the analog path is used; this port has no analog mode and always drives bit clock and frame sync.
// RULE_11: MSB first; data changes on rising clock, sampled on falling clock.
module pcmv_port #(
   parameter int AUDIO_HZ = pcmv_pkg::AUDIO_CLK_HZ,
   parameter int DEPTH = pcmv_pkg::BUF_DEPTH
) (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic audio_clk_i,
   input wire logic tx_valid_i,
   input wire pcmv_pkg::pcmv_sample_type tx_sample_i,
   output logic tx_ready_o,
   output logic rx_valid_o,
   output pcmv_pkg::pcmv_sample_type rx_sample_o,
   input wire logic rx_ready_i,
   output logic rx_overrun_o,
   output logic pcm_clk_o,
   output logic frame_sync_pulse_o,
   output logic pcm_dout_o,
   output logic pcm_dout_oe_o,
   input wire logic pcm_din_i
);
   import pcmv_pkg::*;

   // Half bit period in audio clocks; 2048 kHz needs an exact divisor
   localparam int HALF_RAW = AUDIO_HZ / (2 * BIT_CLK_HZ);
   localparam int HALF_DIV = (HALF_RAW < 1) ? 1 : HALF_RAW;
   localparam int PH_W = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;
   localparam logic [PH_W-1:0] PH_LAST = PH_W'(HALF_DIV - 1);
   localparam logic [PH_W-1:0] PH_STEP = PH_W'(1);
   localparam int CLK_PER = 2 * HALF_DIV;
   localparam int OE_CYC = WORD_BITS * CLK_PER;

   // True inside the data part of a frame
   function automatic logic in_word(input logic [SLOT_W-1:0] s);
      in_word = (s >= SLOT_FIRST_DATA) && (s <= SLOT_LAST_DATA);
   endfunction

   // System side state
   logic tx_head_valid;
   pcmv_sample_type tx_head;
   logic tx_busy;
   logic tx_req;
   pcmv_word_type tx_hold;
   logic ack_chg;
   logic rx_chg;
   logic rx_in_ready;

   // Audio side state
   logic aud_rst_n;
   logic req_chg;
   logic tx_pend;
   logic tx_ack;
   logic stage_full;
   pcmv_word_type tx_stage;
   pcmv_word_type tx_frame;
   pcmv_word_type rx_hold;
   logic [WORD_BITS-1:0] rx_shift;
   logic rx_tgl;
   logic [PH_W-1:0] phase;
   logic [SLOT_W-1:0] slot;
   logic [SLOT_W-1:0] next_slot;
   logic [WORD_IDX_W-1:0] bit_idx;
   logic edge_now;
   logic rise_now;
   logic fall_now;
   logic frame_load;

   /////////////////////////////////////////////////////////////////////////////
   // System clock domain

   // Transmit buffer; it fills since the link drains one word per frame
   pcmv_fifo #(.WIDTH(SAMPLE_BITS), .DEPTH(DEPTH)) u_tx_buf (
      .clk_i(clock_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(tx_valid_i),
      .in_data_i(tx_sample_i),
      .in_ready_o(tx_ready_o),
      .out_valid_o(tx_head_valid),
      .out_data_o(tx_head),
      .out_ready_i(!tx_busy)
   );

   // Word handshake toward the audio side; hold stays put until acknowledged
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         tx_busy <= 1'b0;
         tx_req <= 1'b0;
         tx_hold <= '0;
      end else if (tx_head_valid && !tx_busy) begin
         tx_hold.sample <= tx_head; // [RULE_03]
         tx_hold.pad <= PAD_ZERO; // [RULE_06]
         tx_req <= ~tx_req;
         tx_busy <= 1'b1;
      end else if (ack_chg) begin
         tx_busy <= 1'b0;
      end
   end

   pcmv_sync u_ack_sync (
      .clk_i(clock_i),
      .reset_n_i(reset_n_i),
      .d_i(tx_ack),
      .q_o(),
      .chg_o(ack_chg)
   );

   pcmv_sync u_rx_sync (
      .clk_i(clock_i),
      .reset_n_i(reset_n_i),
      .d_i(rx_tgl),
      .q_o(),
      .chg_o(rx_chg)
   );

   // Receive buffer; rx_hold is stable for a whole frame when read here
   pcmv_fifo #(.WIDTH(SAMPLE_BITS), .DEPTH(DEPTH)) u_rx_buf (
      .clk_i(clock_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(rx_chg),
      .in_data_i(rx_hold.sample),
      .in_ready_o(rx_in_ready),
      .out_valid_o(rx_valid_o),
      .out_data_o(rx_sample_o),
      .out_ready_i(rx_ready_i)
   );

   // The codec cannot be stalled, so a word meeting a full buffer is flagged
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         rx_overrun_o <= 1'b0;
      end else begin
         rx_overrun_o <= rx_chg && !rx_in_ready;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Audio clock domain

   // Reset brought into the audio domain; it releases a few audio clocks late
   pcmv_sync u_rst_sync (
      .clk_i(audio_clk_i),
      .reset_n_i(1'b1),
      .d_i(reset_n_i),
      .q_o(aud_rst_n),
      .chg_o()
   );

   pcmv_sync u_req_sync (
      .clk_i(audio_clk_i),
      .reset_n_i(aud_rst_n),
      .d_i(tx_req),
      .q_o(),
      .chg_o(req_chg)
   );

   assign edge_now = (phase == PH_LAST);
   assign rise_now = edge_now && !pcm_clk_o;
   assign fall_now = edge_now && pcm_clk_o;
   assign next_slot = (slot == SLOT_LAST) ? SLOT_FS : slot + SLOT_STEP;
   assign frame_load = rise_now && (next_slot == SLOT_FS);
   assign bit_idx = WORD_IDX_W'(SLOT_LAST_DATA - next_slot); // [RULE_11]

   // Bit clock divider, free running while out of reset
   always_ff @(posedge audio_clk_i) begin
      if (!aud_rst_n) begin
         phase <= '0;
         pcm_clk_o <= 1'b0;
      end else if (edge_now) begin
         phase <= '0;
         pcm_clk_o <= ~pcm_clk_o; // [RULE_01] [RULE_04]
      end else begin
         phase <= phase + PH_STEP;
      end
   end

   // Staging word; a frame with no word ready sends silence
   always_ff @(posedge audio_clk_i) begin
      if (!aud_rst_n) begin
         tx_pend <= 1'b0;
         tx_ack <= 1'b0;
         stage_full <= 1'b0;
         tx_stage <= '0;
      end else begin
         if (req_chg) begin
            tx_pend <= 1'b1;
         end
         if (frame_load) begin
            stage_full <= 1'b0;
         end
         if (tx_pend && !stage_full) begin
            tx_stage <= tx_hold;
            stage_full <= 1'b1;
            tx_pend <= 1'b0;
            tx_ack <= ~tx_ack;
         end
      end
   end

   // Frame sequencer: slot 0 is sync, slots 1 to 16 carry the word
   always_ff @(posedge audio_clk_i) begin
      if (!aud_rst_n) begin
         slot <= SLOT_LAST;
         frame_sync_pulse_o <= 1'b0;
         pcm_dout_o <= 1'b0;
         pcm_dout_oe_o <= 1'b0;
         tx_frame <= '0;
      end else if (rise_now) begin
         slot <= next_slot;
         frame_sync_pulse_o <= (next_slot == SLOT_FS); // [RULE_05] [RULE_02]
         if (next_slot == SLOT_FS) begin
            tx_frame <= stage_full ? tx_stage : '0;
         end
         if (in_word(next_slot)) begin
            pcm_dout_oe_o <= 1'b1; // [RULE_07]
            pcm_dout_o <= tx_frame[bit_idx]; // [RULE_11] [RULE_06]
         end else begin
            pcm_dout_oe_o <= 1'b0; // [RULE_08] [RULE_09]
            pcm_dout_o <= 1'b0;
         end
      end
   end

   // Receive shifter; din is launched off our own bit clock, so no synchroniser
   always_ff @(posedge audio_clk_i) begin
      if (!aud_rst_n) begin
         rx_shift <= '0;
         rx_hold <= '0;
         rx_tgl <= 1'b0;
      end else if (fall_now && in_word(slot)) begin
         rx_shift <= {rx_shift[WORD_BITS-2:0], pcm_din_i}; // [RULE_11]
         if (slot == SLOT_LAST_DATA) begin
            rx_hold <= {rx_shift[WORD_BITS-2:0], pcm_din_i}; // [RULE_07] [RULE_03]
            rx_tgl <= ~rx_tgl;
         end
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Checks on the link outputs

   logic hlp_clk_q;
   logic hlp_fs_q;
   logic hlp_seen;
   logic [SLOT_W:0] hlp_rises;
   logic [15:0] hlp_oe;

   // Independent counts of bit clocks per frame and of data enable length
   always_ff @(posedge audio_clk_i) begin
      if (!aud_rst_n) begin
         hlp_clk_q <= 1'b0;
         hlp_fs_q <= 1'b0;
         hlp_seen <= 1'b0;
         hlp_rises <= '0;
         hlp_oe <= '0;
      end else begin
         hlp_clk_q <= pcm_clk_o;
         hlp_fs_q <= frame_sync_pulse_o;
         hlp_oe <= pcm_dout_oe_o ? hlp_oe + 16'h0001 : 16'h0000;
         if (pcm_clk_o && !hlp_clk_q) begin
            if (frame_sync_pulse_o && !hlp_fs_q) begin
               hlp_rises <= '0;
               hlp_seen <= 1'b1;
            end else begin
               hlp_rises <= hlp_rises + 9'h001;
            end
         end
      end
   end

   default clocking cb_aud @(posedge audio_clk_i); endclocking
   default disable iff (!aud_rst_n);

   property p_clk_period;
      $rose(pcm_clk_o) |-> ##[CLK_PER:CLK_PER] $rose(pcm_clk_o);
   endproperty
   a_clk_period: assert property (p_clk_period) // [RULE_01]
      else $error("bit clock period wrong");

   property p_frame_len;
      (frame_sync_pulse_o && !hlp_fs_q && hlp_seen)
         |-> (hlp_rises == 9'(SLOTS_PER_FRAME - 1));
   endproperty
   a_frame_len: assert property (p_frame_len) // [RULE_04]
      else $error("frame is not 256 bit clocks");

   property p_fs_width;
      $rose(frame_sync_pulse_o) |-> ##[CLK_PER:CLK_PER] $fell(frame_sync_pulse_o);
   endproperty
   a_fs_width: assert property (p_fs_width) // [RULE_05]
      else $error("sync pulse not one bit clock wide");

   property p_oe_start;
      $fell(frame_sync_pulse_o) |-> $rose(pcm_dout_oe_o);
   endproperty
   a_oe_start: assert property (p_oe_start) // [RULE_07]
      else $error("word does not start as sync falls");

   property p_oe_len;
      $fell(pcm_dout_oe_o) |-> (hlp_oe == 16'(OE_CYC));
   endproperty
   a_oe_len: assert property (p_oe_len) // [RULE_07]
      else $error("word is not 16 bit clocks long");

   property p_dout_quiet;
      !pcm_dout_oe_o |-> !pcm_dout_o;
   endproperty
   a_dout_quiet: assert property (p_dout_quiet) // [RULE_08]
      else $error("data line active outside word");

   property p_fs_float;
      frame_sync_pulse_o |-> !pcm_dout_oe_o;
   endproperty
   a_fs_float: assert property (p_fs_float) // [RULE_09]
      else $error("data driven during sync");

   property p_pad_zero;
      (pcm_dout_oe_o && (slot > SLOT_LAST_SAMPLE)) |-> !pcm_dout_o;
   endproperty
   a_pad_zero: assert property (p_pad_zero) // [RULE_06]
      else $error("pad bit not zero");

   property p_edge_align;
      $changed(pcm_dout_o) |-> $rose(pcm_clk_o);
   endproperty
   a_edge_align: assert property (p_edge_align) // [RULE_11]
      else $error("data changed away from rising clock");

   property p_msb_first;
      $rose(pcm_dout_oe_o) |-> (pcm_dout_o == tx_frame.sample[SAMPLE_BITS-1]);
   endproperty
   a_msb_first: assert property (p_msb_first) // [RULE_03]
      else $error("first bit is not the sample sign bit");

   c_frame: cover property ($rose(frame_sync_pulse_o) && hlp_seen);
   c_underrun: cover property (frame_load && !stage_full && hlp_seen);
   c_rx_word: cover property (@(posedge clock_i) rx_valid_o && rx_ready_i);
   c_tx_full: cover property (@(posedge clock_i) tx_valid_i && !tx_ready_o);
endmodule

`default_nettype wire

// [tb_pcmv_port.sv]
// Self-checking bench for the voiceband PCM master port
`timescale 1ns/1ps
`default_nettype none
module tb_pcmv_port;
   import pcmv_pkg::*;
   // The 125 ns bench link clock stands in, time scaled, for an exact-divisor audio clock
   localparam int AHZ = 4_096_000;
   localparam int FRAME_CYC = 8000;
   localparam int BIT_PS = 250000; // Two link clocks of 125 ns each
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic audio_clk_i = 1'b0;
   logic tx_valid = 1'b0;
   pcmv_sample_type tx_sample = 13'h0001;
   logic rx_ready = 1'b0;
   logic tx_ready, rx_valid, rx_overrun, pcm_clk, fs, dout, dout_oe, din;
   pcmv_sample_type rx_sample;
   pcmv_word_type codec_word = 16'h0008;
   pcmv_word_type cap_word;
   logic frame_tgl, cap_tgl;
   logic stall = 1'b0;
   logic ready_low = 1'b0;
   pcmv_sample_type txq[$];
   pcmv_sample_type rxq[$];
   int seed = 32'he876af98;
   int bad_count = 0;
   int compares = 0;
   int under_cnt = 0;
   int under_base = 0;
   int ovr_cnt = 0;
   int slot = 0;
   bit started = 0;
   realtime last_rise = 0;

   pcmv_port #(.AUDIO_HZ(AHZ), .DEPTH(BUF_DEPTH)) i_pcmv_port (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .audio_clk_i(audio_clk_i),
      .tx_valid_i(tx_valid), .tx_sample_i(tx_sample), .tx_ready_o(tx_ready),
      .rx_valid_o(rx_valid), .rx_sample_o(rx_sample), .rx_ready_i(rx_ready),
      .rx_overrun_o(rx_overrun), .pcm_clk_o(pcm_clk), .frame_sync_pulse_o(fs),
      .pcm_dout_o(dout), .pcm_dout_oe_o(dout_oe), .pcm_din_i(din)
   );
   pcmv_codec_model i_pcmv_codec_model (
      .pcm_clk_i(pcm_clk), .frame_sync_pulse_i(fs), .pcm_dout_i(dout),
      .word_i(codec_word), .pcm_din_o(din), .frame_o(frame_tgl),
      .cap_word_o(cap_word), .cap_o(cap_tgl)
   );
   ////////////////////////////////////////////////////////////////////////////
   // Clocks; the link clock is offset so its edges never meet the system clock
   always #4 clock_i = ~clock_i;
   initial begin
      #13.7;
      forever #62.5 audio_clk_i = ~audio_clk_i;
   end
   // Shared compare and closing tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Zero is kept out so an idle frame of zeros cannot pass for a sample
   function automatic pcmv_sample_type rnd_sample();
      pcmv_sample_type v;
      v = pcmv_sample_type'($random(seed));
      if (v == 0) begin
         v = 13'h0001;
      end
      return v;
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // Transmit driver: each accepted sample is noted for the codec side
   always @(posedge clock_i) begin
      if (reset_n_i === 1'b1 && tx_valid && tx_ready === 1'b1) begin
         txq.push_back(tx_sample);
         tx_sample <= rnd_sample();
      end
      if (reset_n_i === 1'b1 && tx_ready === 1'b0) begin
         ready_low <= 1'b1;
      end
      rx_ready <= !stall && (($random(seed) & 3) != 0);
   end
   // Receive watcher; a dropped word is always the newest one noted
   always @(posedge clock_i) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
         check(rx_sample, rxq.pop_front());
      end
      if (rx_overrun === 1'b1) begin
         void'(rxq.pop_back());
         ovr_cnt++;
      end
   end
   // Codec latched its word for this frame: note it, choose the next
   always @(frame_tgl) begin
      if (reset_n_i === 1'b1) begin
         rxq.push_back(codec_word.sample);
         codec_word = {rnd_sample(), PAD_ZERO};
      end
   end
   // Word captured by the codec; all zeros means the frame had nothing staged
   always @(cap_tgl) begin
      if (reset_n_i === 1'b1) begin
         if (cap_word === 16'h0000) begin
            under_cnt++;
         end else begin
            check(cap_word, {txq.pop_front(), PAD_ZERO});
         end
      end
   end
   // Link monitor: frame spacing, sync width, enable window and idle level
   always @(negedge pcm_clk) begin
      if (reset_n_i === 1'b1 && fs === 1'b1) begin
         if (started) begin
            check(slot + 1, SLOTS_PER_FRAME);
         end
         started = 1;
         slot = 0;
      end else begin
         slot++;
      end
      if (started) begin
         check(dout_oe, slot >= FIRST_DATA_SLOT && slot <= LAST_DATA_SLOT);
         if (dout_oe !== 1'b1) begin
            check(dout, 0);
         end
      end
   end
   // Bit clock period
   always @(posedge pcm_clk) begin
      if (started) begin
         check(int'(($realtime - last_rise) * 1000), BIT_PS);
      end
      last_rise = $realtime;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence; reset also spans eight link clocks
   initial begin
      repeat (130) @(posedge clock_i);
      reset_n_i <= 1'b1;
      tx_valid <= 1'b1;
      repeat (2 * FRAME_CYC) @(posedge clock_i);
      check(ovr_cnt, 0);
      check(ready_low, 1);
      // Only the frames sent before the first word was staged may be empty
      under_base = under_cnt;
      check(under_base < 3, 1);
      $display("test stream and tx back-pressure done");
      stall <= 1'b1;
      repeat (3 * FRAME_CYC) @(posedge clock_i);
      stall <= 1'b0;
      repeat (FRAME_CYC) @(posedge clock_i);
      check(ovr_cnt > 0, 1);
      $display("test rx stall and overrun done");
      // A steady stream must never let a frame go out empty
      check(under_cnt, under_base);
      tx_valid <= 1'b0;
      // Up to four words are still in flight, so six frames make an empty one certain
      repeat (6 * FRAME_CYC) @(posedge clock_i);
      check(under_cnt > under_base, 1);
      $display("test tx underrun done");
      conclude();
   end
   // Watchdog reckoned from the twelve frames above plus margin
   initial begin
      #1_000_000;
      bad_count++;
      conclude();
   end
endmodule
`default_nettype wire
